// [hdl/meter_clock_generator.sv]
// Metering clock generator: master divider, derived clocks, APB registers
`timescale 1ns/1ps
`include "meter_clock_params.svh"
module meter_clock_generator
  import meter_clock_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock sources as enable pulses
  input  wire logic        pll_edge_tick,
  input  wire logic        xtal_tick,
  // Power modes
  input  wire logic        sleep_mode,
  input  wire logic        brownout_mode,
  // Derived clock enables
  output logic             pll_enable,
  output logic             master_clock_en,
  output logic             processor_clock_en,
  output logic             emulator_clock_en,
  output logic             compute_engine_clock_en,
  output logic             converter_clock_en,
  output logic             decimator_clock_en,
  output logic             slow_reference_clock_en,
  output logic             timer_clock_en
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         cfg_div2;
    logic         cfg_div3;
    logic         cfg_ce2x;
    logic [2:0]   cfg_processor_clock_divider;
    logic         cfg_emulator_clock_disable;
    master_mode_e mode;
    logic [8:0]   bin_count;
    logic [10:0]  slow_count;
    logic [2:0]   swallow;
    logic         pll_enable;
    logic         master_clock_en;
    logic         processor_clock_en;
    logic         emulator_clock_en;
    logic         compute_engine_clock_en;
    logic         converter_clock_en;
    logic         decimator_clock_en;
    logic         slow_reference_clock_en;
    logic         timer_clock_en;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
  } gen_state_s;

  gen_state_s q;
  gen_state_s next_q;

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  master_mode_e mode_sel;
  logic         restart;
  logic [2:0]   master_ratio;
  logic         source_tick;
  logic         master_tick;
  logic [2:0]   processor_clock_divider_eff;
  logic [3:0]   mpu_exp;
  logic [8:0]   mpu_mask;
  logic [8:0]   emu_mask;
  logic [8:0]   ce_mask;
  logic [8:0]   adc_mask;
  logic [10:0]  slow_div;
  logic [11:0]  pll_measured;
  logic         pll_ratio_ok;
  logic         apb_setup;
  logic         apb_done;
  logic         addr_cfg;
  logic         addr_status;
  logic [31:0]  cfg_word;
  logic [31:0]  status_word;

  always_comb begin
    // Brownout wins over sleep: only brownout takes the PLL down, sleep keeps it running at divide-by-4
    if (brownout_mode) begin
      mode_sel = mode_brownout;
    end else if (sleep_mode) begin
      mode_sel = mode_div4;
    end else if (q.cfg_div2) begin
      mode_sel = mode_div2;
    end else if (q.cfg_div3) begin
      mode_sel = mode_div3;
    end else begin
      mode_sel = mode_div4;
    end
  end

  // A mode switch restarts every count so the clocks start aligned
  assign restart = (mode_sel != q.mode);

  always_comb begin
    case (q.mode)
      mode_div2: begin
        master_ratio = `RATIO_DIV2;
        slow_div     = `SLOW_DIV2;
        ce_mask      = q.cfg_ce2x ? `MASK_BY4 : `MASK_BY8;
        adc_mask     = `MASK_BY8;
      end
      mode_div3: begin
        master_ratio = `RATIO_DIV3;
        slow_div     = `SLOW_DIV3;
        ce_mask      = `MASK_BY4;
        adc_mask     = `MASK_BY4;
      end
      mode_brownout: begin
        master_ratio = `RATIO_BROWN;
        slow_div     = `SLOW_DIV4;
        ce_mask      = `MASK_BY4;
        adc_mask     = `MASK_BY4;
      end
      default: begin
        master_ratio = `RATIO_DIV4;
        slow_div     = `SLOW_DIV4;
        ce_mask      = `MASK_BY4;
        adc_mask     = `MASK_BY4;
      end
    endcase
  end

  // Brownout drops one crystal edge in eight for the 7/8 scaling
  always_comb begin
    if (q.mode == mode_brownout) begin
      source_tick = xtal_tick && (q.swallow != `SWALLOW_SLOT);
    end else begin
      source_tick = pll_edge_tick;
    end
  end

  always_comb begin
    if (q.cfg_processor_clock_divider > `PROCESSOR_CLOCK_DIVIDER_MAX) begin
      processor_clock_divider_eff = `PROCESSOR_CLOCK_DIVIDER_MAX;
    end else begin
      processor_clock_divider_eff = q.cfg_processor_clock_divider;
    end
    mpu_exp  = 4'({1'b0, processor_clock_divider_eff} + `MPU_EXP_BASE);
    mpu_mask = 9'((9'h001 << mpu_exp) - 9'h001);
    emu_mask = {1'b0, mpu_mask[8:1]};
  end

  // ----------------------------------------------------------------
  // Master divider and PLL check
  // ----------------------------------------------------------------
  tick_divider #(
    .W (3)
  ) u_master_div (
    .clock    (clock),
    .rst_n    (rst_sync_n),
    .restart  (restart),
    .ratio    (master_ratio),
    .tick_in  (source_tick),
    .tick_out (master_tick)
  );

  pll_ratio_monitor u_pll_mon (
    .clock     (clock),
    .rst_n     (rst_sync_n),
    .pll_tick  (pll_edge_tick),
    .xtal_tick (xtal_tick),
    .measured  (pll_measured),
    .ratio_ok  (pll_ratio_ok)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: pready rises on the second access cycle
  assign apb_setup   = psel && penable && !q.pready;
  assign apb_done    = psel && penable && q.pready;
  assign addr_cfg    = (paddr == `CFG_OFFSET);
  assign addr_status = (paddr == `STATUS_OFFSET);

  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`CFG_DIV2_BIT] = q.cfg_div2;
    cfg_word[`CFG_DIV3_BIT] = q.cfg_div3;
    cfg_word[`CFG_CE2X_BIT] = q.cfg_ce2x;
    cfg_word[`CFG_MPU_MSB:`CFG_MPU_LSB] = q.cfg_processor_clock_divider;
    cfg_word[`CFG_EMULATOR_CLOCK_DISABLE_BIT] = q.cfg_emulator_clock_disable;
    status_word = 32'h0000_0000;
    status_word[`STAT_MODE_MSB:`STAT_MODE_LSB] = q.mode;
    status_word[`STAT_SLEEP_BIT] = sleep_mode;
    status_word[`STAT_BROWN_BIT] = brownout_mode;
    status_word[`STAT_PLL_OK_BIT] = pll_ratio_ok;
    status_word[`STAT_COUNT_MSB:`STAT_COUNT_LSB] = pll_measured;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.mode = mode_sel;
    next_q.pll_enable = (mode_sel != mode_brownout);
    next_q.master_clock_en = 1'b0;
    next_q.processor_clock_en = 1'b0;
    next_q.emulator_clock_en = 1'b0;
    next_q.compute_engine_clock_en = 1'b0;
    next_q.converter_clock_en = 1'b0;
    next_q.decimator_clock_en = 1'b0;
    next_q.slow_reference_clock_en = 1'b0;
    next_q.timer_clock_en = 1'b0;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;

    // Register bus
    if (apb_setup) begin
      next_q.pready = 1'b1;
      next_q.pslverr = !(addr_cfg || addr_status);
      if (!pwrite && addr_cfg) begin
        next_q.prdata = cfg_word;
      end else if (!pwrite && addr_status) begin
        next_q.prdata = status_word;
      end else begin
        next_q.prdata = 32'h0000_0000;
      end
    end
    if (apb_done && pwrite && addr_cfg) begin
      next_q.cfg_div2 = pwdata[`CFG_DIV2_BIT];
      next_q.cfg_div3 = pwdata[`CFG_DIV3_BIT];
      next_q.cfg_ce2x = pwdata[`CFG_CE2X_BIT];
      next_q.cfg_processor_clock_divider = pwdata[`CFG_MPU_MSB:`CFG_MPU_LSB];
      next_q.cfg_emulator_clock_disable = pwdata[`CFG_EMULATOR_CLOCK_DISABLE_BIT];
    end

    // Crystal edge swallower
    if (restart) begin
      next_q.swallow = 3'h0;
    end else if (xtal_tick && (q.mode == mode_brownout)) begin
      next_q.swallow = 3'(q.swallow + 3'h1);
    end

    // Derived clocks, decoded from the bin and slow counts of master edges
    if (restart) begin
      next_q.bin_count = 9'h000;
      next_q.slow_count = 11'h000;
    end else if (master_tick) begin
      next_q.master_clock_en = 1'b1;
      next_q.bin_count = 9'(q.bin_count + 9'h001);
      if (q.slow_count >= 11'(slow_div - 11'h001)) begin
        next_q.slow_count = 11'h000;
      end else begin
        next_q.slow_count = 11'(q.slow_count + 11'h001);
      end
      next_q.processor_clock_en = (q.bin_count & mpu_mask) == 9'h000;
      next_q.timer_clock_en = (q.bin_count & mpu_mask) == 9'h000;
      next_q.emulator_clock_en =
        !q.cfg_emulator_clock_disable && ((q.bin_count & emu_mask) == 9'h000);
      next_q.converter_clock_en = (q.bin_count & adc_mask) == 9'h000;
      next_q.decimator_clock_en = (q.bin_count & adc_mask) == 9'h000;
      if (q.mode != mode_brownout) begin
        next_q.compute_engine_clock_en =
          (q.bin_count & ce_mask) == 9'h000;
        next_q.slow_reference_clock_en = (q.slow_count == 11'h000);
      end
    end
    // In brownout the slow reference is the crystal itself
    if (q.mode == mode_brownout) begin
      next_q.slow_reference_clock_en = xtal_tick;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '0;
      q.cfg_div2 <= 1'b0;
      q.cfg_div3 <= 1'b0;
      q.cfg_emulator_clock_disable <= 1'(`CFG_RESET >> `CFG_EMULATOR_CLOCK_DISABLE_BIT);
      q.mode <= mode_div4;
      q.pll_enable <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata                  = q.prdata;
  assign pready                  = q.pready;
  assign pslverr                 = q.pslverr;
  assign pll_enable              = q.pll_enable;
  assign master_clock_en         = q.master_clock_en;
  assign processor_clock_en      = q.processor_clock_en;
  assign emulator_clock_en       = q.emulator_clock_en;
  assign compute_engine_clock_en = q.compute_engine_clock_en;
  assign converter_clock_en      = q.converter_clock_en;
  assign decimator_clock_en      = q.decimator_clock_en;
  assign slow_reference_clock_en = q.slow_reference_clock_en;
  assign timer_clock_en          = q.timer_clock_en;

endmodule : meter_clock_generator

// [hdl/meter_clock_params.svh]
// Register offsets, field positions, reset values and divide counts
`ifndef METER_CLOCK_PARAMS_SVH
`define METER_CLOCK_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS   100
`define PLL_MULTIPLY      12'h960

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define CFG_OFFSET        12'h000
`define STATUS_OFFSET     12'h004

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_DIV2_BIT      0
`define CFG_DIV3_BIT      1
`define CFG_CE2X_BIT      2
`define CFG_MPU_LSB       4
`define CFG_MPU_MSB       6
`define CFG_EMULATOR_CLOCK_DISABLE_BIT   8
`define CFG_RESET         32'h0000_0100

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define STAT_MODE_LSB     0
`define STAT_MODE_MSB     1
`define STAT_SLEEP_BIT    2
`define STAT_BROWN_BIT    3
`define STAT_PLL_OK_BIT   4
`define STAT_COUNT_LSB    16
`define STAT_COUNT_MSB    27

// ----------------------------------------------------------------
// Divide counts
// ----------------------------------------------------------------
`define RATIO_DIV2        3'h2
`define RATIO_DIV3        3'h3
`define RATIO_DIV4        3'h4
`define RATIO_BROWN       3'h1
`define MASK_BY4          9'h003
`define MASK_BY8          9'h007
`define SLOW_DIV2         11'h4B0
`define SLOW_DIV3         11'h320
`define SLOW_DIV4         11'h258
`define SWALLOW_SLOT      3'h7
`define PROCESSOR_CLOCK_DIVIDER_MAX       3'h6
`define MPU_EXP_BASE      4'h2

`endif

// [hdl/meter_clock_pkg.sv]
// Types shared by the clock generator modules
package meter_clock_pkg;

  // ----------------------------------------------------------------
  // Master clock source mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_div2,
    mode_div3,
    mode_div4,
    mode_brownout
  } master_mode_e;

endpackage : meter_clock_pkg

// [hdl/tick_divider.sv]
// Divides a stream of enable pulses by a run-time ratio
`timescale 1ns/1ps
`include "meter_clock_params.svh"
module tick_divider
  import meter_clock_pkg::*;
#(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Control
  input  wire logic         restart,
  input  wire logic [W-1:0] ratio,
  // Pulses
  input  wire logic         tick_in,
  output logic              tick_out
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick_out;
  } div_state_s;

  div_state_s q;
  div_state_s next_q;

  always_comb begin
    next_q = q;
    next_q.tick_out = 1'b0;
    if (restart) begin
      next_q.count = '0;
    end else if (tick_in) begin
      if (q.count >= W'(ratio - W'(1))) begin
        next_q.count = '0;
        next_q.tick_out = 1'b1;
      end else begin
        next_q.count = W'(q.count + W'(1));
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick_out = q.tick_out;

endmodule : tick_divider

// [hdl/pll_ratio_monitor.sv]
// Counts PLL edges per crystal period and checks the multiply factor
`timescale 1ns/1ps
`include "meter_clock_params.svh"
module pll_ratio_monitor
  import meter_clock_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Edge pulses
  input  wire logic        pll_tick,
  input  wire logic        xtal_tick,
  // Result
  output logic [11:0]      measured,
  output logic             ratio_ok
);

  typedef struct packed {
    logic [11:0] count;
    logic [11:0] measured;
    logic        ratio_ok;
  } mon_state_s;

  mon_state_s q;
  mon_state_s next_q;

  always_comb begin
    next_q = q;
    if (xtal_tick) begin
      next_q.measured = q.count;
      next_q.ratio_ok = (q.count == `PLL_MULTIPLY);
      next_q.count = {11'h000, pll_tick};
    end else if (pll_tick && (q.count != 12'hFFF)) begin
      // Saturate so a runaway PLL never wraps into a false match
      next_q.count = 12'(q.count + 12'h001);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign measured = q.measured;
  assign ratio_ok = q.ratio_ok;

endmodule : pll_ratio_monitor

// [verif/meter_clock_partner.sv]
// Behavioural PLL and crystal pulse sources feeding the clock generator
`timescale 1ns/1ps
module meter_clock_partner (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Control
  input  wire logic pll_enable,
  input  wire logic fast_xtal,
  // Source pulses
  output logic      pll_edge_tick,
  output logic      xtal_tick
);
  // ----------------------------------------------------------------
  // Sources
  // ----------------------------------------------------------------
  // A fast crystal keeps brownout runs short; ratios stay exact
  logic [12:0] xcount;
  logic        phase;
  wire  logic [12:0] lim = fast_xtal ? 13'h0003 : 13'h12BF;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xcount        <= '0;
      phase         <= 1'b0;
      pll_edge_tick <= 1'b0;
      xtal_tick     <= 1'b0;
    end else begin
      phase         <= ~phase;
      pll_edge_tick <= pll_enable && phase;
      xcount        <= (xcount >= lim) ? 13'h0000 : xcount + 13'h0001;
      xtal_tick     <= (xcount == 13'h0000);
    end
  end
endmodule : meter_clock_partner

// [verif/meter_clock_generator_checker.sv]
// Concurrent checks on the clock generator ports
`timescale 1ns/1ps
module meter_clock_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sources and modes
  input wire logic        pll_edge_tick,
  input wire logic        xtal_tick,
  input wire logic        sleep_mode,
  input wire logic        brownout_mode,
  // Enables
  input wire logic        pll_enable,
  input wire logic        master_clock_en,
  input wire logic        processor_clock_en,
  input wire logic        emulator_clock_en,
  input wire logic        compute_engine_clock_en,
  input wire logic        converter_clock_en,
  input wire logic        decimator_clock_en,
  input wire logic        slow_reference_clock_en,
  input wire logic        timer_clock_en
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  // Checks on enables wait out the restart after any mode change
  logic       emulator_clock_disable;
  logic       sleep_q;
  logic       brown_q;
  logic [4:0] settle;
  wire  logic cfg_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  wire  logic calm   = settle == 5'h1F && !brownout_mode;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      emulator_clock_disable <= 1'b1;
      sleep_q <= 1'b0;
      brown_q <= 1'b0;
      settle  <= '0;
    end else begin
      sleep_q <= sleep_mode;
      brown_q <= brownout_mode;
      if (cfg_wr) emulator_clock_disable <= pwdata[8];
      if (cfg_wr || sleep_q != sleep_mode || brown_q != brownout_mode)
        settle <= '0;
      else if (settle != 5'h1F)
        settle <= settle + 5'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_access;
    $rose(psel && penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  a_apb_one_wait: assert property (s_access |-> s_one_wait)
    else $error("access did not finish after one wait state");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (pready && !(paddr inside {12'h000,
    12'h004}) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr inside {12'h000, 12'h004}
    |-> !pslverr) else $error("mapped access refused");
  a_emu_disabled: assert property (
    calm && emulator_clock_disable |-> !emulator_clock_en)
    else $error("emulator pulse while disabled");
  a_emu_double: assert property (
    calm && !emulator_clock_disable && processor_clock_en |-> emulator_clock_en)
    else $error("emulator not aligned");
  a_proc_aligned: assert property (calm && processor_clock_en
    |-> master_clock_en) else $error("processor pulse off master");
  a_engine_aligned: assert property (calm && (compute_engine_clock_en
    || converter_clock_en) |-> master_clock_en)
    else $error("engine or converter pulse off master");
  a_fir_with_adc: assert property (
    converter_clock_en == decimator_clock_en)
    else $error("decimator differs from converter");
  a_timer_follow: assert property (calm |-> timer_clock_en
    == processor_clock_en) else $error("timer enable differs");
  a_brown_pll_off: assert property (
    brownout_mode [*4] |-> !pll_enable)
    else $error("pll on in brownout");
  a_pll_on: assert property (!brownout_mode [*4] |-> pll_enable)
    else $error("pll off outside brownout");
endmodule : meter_clock_checker

bind meter_clock_generator meter_clock_checker i_chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pll_edge_tick(pll_edge_tick),
  .xtal_tick(xtal_tick), .sleep_mode(sleep_mode),
  .brownout_mode(brownout_mode), .pll_enable(pll_enable),
  .master_clock_en(master_clock_en),
  .processor_clock_en(processor_clock_en),
  .emulator_clock_en(emulator_clock_en),
  .compute_engine_clock_en(compute_engine_clock_en),
  .converter_clock_en(converter_clock_en),
  .decimator_clock_en(decimator_clock_en),
  .slow_reference_clock_en(slow_reference_clock_en),
  .timer_clock_en(timer_clock_en));

// [verif/tb_meter_clock_generator.sv]
// Self-checking bench for the metering clock generator
`timescale 1ns/1ps
module tb_meter_clock_generator;
  import meter_clock_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, er;
  logic        sleep_mode, brownout_mode, fast_xtal, pll_enable;
  logic        pll_edge_tick, xtal_tick, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire logic [7:0] en;
  int          n_errors, num_checks, m;
  localparam int MST = 0, PRC = 1, EMU = 2, CE = 3;
  localparam int CNV = 4, DEC = 5, SLW = 6, TMR = 7;
  // Per mode: config, status mode, master ratio, engine and converter divide
  logic [31:0] cfg [5] = '{32'h0000_0001, 32'h0000_0005, 32'h0000_0002,
                           32'h0000_0000, 32'h0000_0003};
  int mode [5] = '{0, 0, 1, 2, 0};
  int ratio [5] = '{2, 2, 3, 4, 2};
  int cediv [5] = '{8, 4, 4, 4, 8};
  int cvdiv [5] = '{8, 8, 4, 4, 8};

  meter_clock_generator i_dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pll_edge_tick(pll_edge_tick),
    .xtal_tick(xtal_tick), .sleep_mode(sleep_mode),
    .brownout_mode(brownout_mode), .pll_enable(pll_enable),
    .master_clock_en(en[MST]), .processor_clock_en(en[PRC]),
    .emulator_clock_en(en[EMU]), .compute_engine_clock_en(en[CE]),
    .converter_clock_en(en[CNV]), .decimator_clock_en(en[DEC]),
    .slow_reference_clock_en(en[SLW]), .timer_clock_en(en[TMR]));

  meter_clock_partner i_src (
    .clock(clock), .rst_n(rst_n), .pll_enable(pll_enable),
    .fast_xtal(fast_xtal), .pll_edge_tick(pll_edge_tick),
    .xtal_tick(xtal_tick));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic hang();
    n_errors++;
    final_report();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until ready is seen, released after the taking edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    // Ready is seen as the edge samples it; data is taken at that edge
    do begin
      @(posedge clock);
      k++;
      if (k > 20) hang();
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdf(input logic [11:0] a, input logic [31:0] msk,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & msk, e);
    chk({31'h0, er}, 32'h0000_0000);
  endtask : rdf

  task automatic wait_en(input int i, inout int k);
    do begin
      @(negedge clock);
      k++;
      if (k > 10000) hang();
    end while (en[i] !== 1'b1);
  endtask : wait_en

  task automatic per(input int i, input int exp);
    int k;
    k = 0;
    wait_en(i, k);
    k = 0;
    wait_en(i, k);
    chk(k, exp);
  endtask : per

  task automatic cnt(input int i, input int n, input int exp);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge clock);
      if (en[i] === 1'b1) k++;
    end
    chk(k, exp);
  endtask : cnt

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    {rst_n, psel, penable, pwrite, sleep_mode, brownout_mode} = '0;
    {fast_xtal, paddr, pwdata, n_errors, num_checks} = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rdf(12'h000, 32'hFFFF_FFFF, 32'h0000_0100);
    rdf(12'h004, 32'h0000_000F, 32'h0000_0002);
    per(MST, 8);
    apb(1'b1, 12'h008, 32'h0000_0001);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h0000_0000);
    rdf(12'h000, 32'hFFFF_FFFF, 32'h0000_0100);
    for (int r = 0; r < 5; r++) begin
      apb(1'b1, 12'h000, cfg[r]);
      rdf(12'h000, 32'hFFFF_FFFF, cfg[r]);
      rdf(12'h004, 32'h0000_0003, mode[r]);
      m = 2 * ratio[r];
      per(MST, m);
      per(CE, m * cediv[r]);
      per(CNV, m * cvdiv[r]);
      per(DEC, m * cvdiv[r]);
      per(PRC, m * 4);
      per(EMU, m * 2);
      per(SLW, 4800);
    end
    rdf(12'h004, 32'h0FFF_0010, 32'h0960_0010);
    apb(1'b1, 12'h000, 32'h0000_0061);
    per(PRC, 1024);
    per(TMR, 1024);
    per(EMU, 512);
    apb(1'b1, 12'h000, 32'h0000_0071);
    rdf(12'h000, 32'hFFFF_FFFF, 32'h0000_0071);
    per(PRC, 1024);
    apb(1'b1, 12'h000, 32'h0000_0101);
    repeat (8) @(posedge clock);
    cnt(EMU, 200, 0);
    @(posedge clock);
    sleep_mode <= 1'b1;
    repeat (8) @(posedge clock);
    per(MST, 8);
    rdf(12'h004, 32'h0000_0007, 32'h0000_0006);
    @(posedge clock);
    sleep_mode    <= 1'b0;
    fast_xtal     <= 1'b1;
    brownout_mode <= 1'b1;
    repeat (16) @(negedge clock);
    chk({31'h0, pll_enable}, 32'h0000_0000);
    rdf(12'h004, 32'h0000_000F, 32'h0000_000B);
    cnt(MST, 128, 28);
    cnt(CNV, 128, 7);
    cnt(CE, 128, 0);
    cnt(SLW, 128, 32);
    @(posedge clock);
    brownout_mode <= 1'b0;
    fast_xtal     <= 1'b0;
    repeat (16) @(negedge clock);
    chk({31'h0, pll_enable}, 32'h0000_0001);
    per(MST, 4);
    final_report();
  end
endmodule : tb_meter_clock_generator
